// File: common/slpx_defines.svh
/*
 * Offsets, field positions, reset values and timing figures of the sleep
 * and execution-command controller.
 * Assumes a 125 MHz system clock and a plain 8-bit byte-addressed port.
 */
`ifndef SLPX_DEFINES_SVH
`define SLPX_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define SLPX_ADDR_MODE    8'h00
`define SLPX_ADDR_PERIOD  8'h04
`define SLPX_ADDR_OPTIONS 8'h08
`define SLPX_ADDR_WAKEDLY 8'h0c
`define SLPX_ADDR_WAKETM  8'h10
`define SLPX_ADDR_ASSOC   8'h14
`define SLPX_ADDR_RATE    8'h18
`define SLPX_ADDR_CMD     8'h1c
`define SLPX_ADDR_STATUS  8'h20
`define SLPX_ADDR_ACTIVE  8'h40
`define SLPX_ADDR_TOP     8'h58

// ----------------------------------------------------------------------
// command register bits (write one to act)
// ----------------------------------------------------------------------
`define SLPX_CMD_APPLY    0
`define SLPX_CMD_SAVE     1
`define SLPX_CMD_RESTORE  2
`define SLPX_CMD_REBOOT   3
`define SLPX_CMD_NETCLR   4
`define SLPX_CMD_LEAVE    5
`define SLPX_CMD_API08    6

// ----------------------------------------------------------------------
// parameter slots, reset values and upper limits
// ----------------------------------------------------------------------
`define SLPX_NPARAM       7
`define SLPX_IDX_MODE     3'h0
`define SLPX_IDX_PERIOD   3'h1
`define SLPX_IDX_OPTIONS  3'h2
`define SLPX_IDX_WAKEDLY  3'h3
`define SLPX_IDX_WAKETM   3'h4
`define SLPX_IDX_ASSOC    3'h5
`define SLPX_IDX_RATE     3'h6
`define SLPX_IDX_LAST     3'h6
`define SLPX_DEF_MODE     24'h000000
`define SLPX_DEF_PERIOD   24'h0000c8
`define SLPX_DEF_OPTIONS  24'h000100
`define SLPX_DEF_WAKEDLY  24'h000000
`define SLPX_DEF_WAKETM   24'h0007d0
`define SLPX_DEF_ASSOC    24'h002710
`define SLPX_DEF_RATE     24'h000003
`define SLPX_MAX_PERIOD   24'h83d600
`define SLPX_MAX_OPTIONS  24'h0001ff
`define SLPX_MAX_WAKEDLY  24'h00ffff
`define SLPX_MAX_MSTIME   24'h36ee80
`define SLPX_MAX_RATE     24'h00000f
`define SLPX_OPT_KEEPASSOC 6
`define SLPX_OPT_NORESTART 8

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SLPX_CLK_PERIOD_NS 8
`define SLPX_MS_NS         1000000
`define SLPX_TICKS_PER_10MS 4'h9
`define SLPX_REBOOT_MS     11'd2000

`endif

// File: common/slpx_nv_if.sv
/*
 * Carrier between the controller and its non-volatile parameter store.
 * Assumes one clock; read data follow the address by one cycle.
 */
`timescale 1ns/1ps

interface slpx_nv_if;
	import slpx_pkg::*;
	logic       we;
	slpx_idx_t  addr;
	slpx_word_t wdata;
	slpx_word_t rdata;

	modport ctrl (output we, output addr, output wdata, input rdata);
	modport mem  (input we, input addr, input wdata, output rdata);
endinterface : slpx_nv_if

// File: common/slpx_pkg.sv
/*
 * Types and the reset-value lookup of the sleep and execution controller.
 * Assumes slpx_defines.svh is on the include path.
 */
`include "slpx_defines.svh"

package slpx_pkg;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef logic [23:0] slpx_word_t;
	typedef logic [2:0]  slpx_idx_t;

	typedef enum logic [2:0] {
		SLPX_MODE_NONE   = 3'h0,
		SLPX_MODE_PIN    = 3'h1,
		SLPX_MODE_CYC    = 3'h4,
		SLPX_MODE_CYCPIN = 3'h5
	} slpx_mode_t;

	typedef enum logic [2:0] {
		SLPX_AWAKE = 3'h0,
		SLPX_WAKE  = 3'h1,
		SLPX_DRAIN = 3'h2,
		SLPX_ASSOC = 3'h3,
		SLPX_SLEEP = 3'h4
	} slpx_state_t;

	// factory value of each parameter slot
	function automatic slpx_word_t slpxDefault(input slpx_idx_t i);
		unique case (i)
			`SLPX_IDX_MODE:    slpxDefault = `SLPX_DEF_MODE;
			`SLPX_IDX_PERIOD:  slpxDefault = `SLPX_DEF_PERIOD;
			`SLPX_IDX_OPTIONS: slpxDefault = `SLPX_DEF_OPTIONS;
			`SLPX_IDX_WAKEDLY: slpxDefault = `SLPX_DEF_WAKEDLY;
			`SLPX_IDX_WAKETM:  slpxDefault = `SLPX_DEF_WAKETM;
			`SLPX_IDX_ASSOC:   slpxDefault = `SLPX_DEF_ASSOC;
			default:           slpxDefault = `SLPX_DEF_RATE;
		endcase
	endfunction : slpxDefault

endpackage : slpx_pkg

// File: dv/slpx_host_model.sv
/* stand-in for the host pins and the network side of the controller.
   assumes the bench calls its tasks from a process that follows clk. */
`timescale 1ns/1ps
module slpx_host_model (
	input  wire logic clk,
	output logic      sleepPin,
	output logic      serialCharRx,
	output logic      workPending,
	output logic      associated,
	output logic      cmdModeTimeout
);
	// ------------------------------------------------------------------
	// pin and event drivers
	// ------------------------------------------------------------------
	// link stays up and idle so sleep is never deferred
	initial begin
		sleepPin       = 1'b0;
		serialCharRx   = 1'b0;
		workPending    = 1'b0;
		associated     = 1'b1;
		cmdModeTimeout = 1'b0;
	end
	task automatic set_pin(input logic v);
		@(posedge clk);
		sleepPin <= v;
	endtask : set_pin
	// one character from the host, a single-cycle event
	task automatic pulse_char();
		@(posedge clk);
		serialCharRx <= 1'b1;
		@(posedge clk);
		serialCharRx <= 1'b0;
	endtask : pulse_char
	task automatic pulse_timeout();
		@(posedge clk);
		cmdModeTimeout <= 1'b1;
		@(posedge clk);
		cmdModeTimeout <= 1'b0;
	endtask : pulse_timeout
endmodule : slpx_host_model

// File: dv/slpx_sleep_exec_monitor.sv
/* port checker of the sleep and execution controller.
   assumes it is bound onto slpx_sleep_exec; one clock domain. */
`timescale 1ns/1ps
`include "slpx_defines.svh"
module slpx_sleep_exec_monitor #(
	parameter int MS_CYCLES = 4
) (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [7:0]  regAddr,
	input wire logic [23:0] regWdata,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [23:0] regRdata,
	input wire logic        asleep,
	input wire logic        keepAssoc,
	input wire logic        hostOutputEnable,
	input wire logic [7:0]  serialRate,
	input wire logic        okPulse,
	input wire logic        netClearPulse,
	input wire logic        softResetPulse
);
	// ------------------------------------------------------------------
	// port relations
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	logic cmdWr;
	logic netCmd;
	// command decode kept outside $past so it sees a plain signal
	assign cmdWr  = regWr && regAddr == `SLPX_ADDR_CMD;
	assign netCmd = cmdWr && regWdata[`SLPX_CMD_NETCLR];
	rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 24'h0)
		else $error("read data seen outside the read answer cycle");
	apply_ok_a: assert property (cmdWr && regWdata[0] |=> okPulse)
		else $error("apply command gave no ok pulse");
	reboot_ok_a: assert property (cmdWr && regWdata[3] |=> okPulse)
		else $error("reboot command gave no immediate ok pulse");
	netclr_resp_a: assert property (netCmd |=> netClearPulse)
		else $error("network clear command gave no pulse");
	netclr_cause_a: assert property (netClearPulse |-> $past(netCmd))
		else $error("network clear pulse without a command");
	keep_assoc_a: assert property (keepAssoc |-> asleep)
		else $error("association kept while awake");
	host_hold_a: assert property (asleep |-> !hostOutputEnable)
		else $error("host output allowed while asleep");
	rate_max_a: assert property (serialRate <= 8'h0f)
		else $error("active serial rate out of range");
	reboot_once_a: assert property (softResetPulse |=> !softResetPulse [*8])
		else $error("soft reset pulse repeated");
	// main scenarios reached
	cover property (okPulse);
	cover property (netClearPulse);
	cover property (keepAssoc);
	cover property (softResetPulse);
endmodule : slpx_sleep_exec_monitor

bind slpx_sleep_exec slpx_sleep_exec_monitor #(.MS_CYCLES(MS_CYCLES))
	slpx_sleep_exec_monitor_inst (.clk(clk), .nrst(nrst), .regAddr(regAddr),
	.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.asleep(asleep), .keepAssoc(keepAssoc),
	.hostOutputEnable(hostOutputEnable), .serialRate(serialRate),
	.okPulse(okPulse), .netClearPulse(netClearPulse),
	.softResetPulse(softResetPulse));

// File: dv/slpx_sleep_exec_tb.sv
/* self-checking bench of the sleep and execution controller.
   assumes MS_CYCLES of 4, so the reboot delay is about 8000 cycles. */
`timescale 1ns/1ps
`include "slpx_defines.svh"
module slpx_sleep_exec_tb;
	logic        clk = 1'b0;
	logic        nrst, regWr, regRd, asleep, keepAssoc, hostOutputEnable;
	logic        okPulse, netClearPulse, softResetPulse;
	logic        sleepPin, serialCharRx, workPending, associated, cmdModeTimeout;
	logic [7:0]  regAddr, serialRate;
	logic [23:0] regWdata, regRdata;
	int          err_count, compares, okCount, nclrCount, rstCount, okExp, cyc;
	logic [23:0] modes[4] = '{24'h1, 24'h4, 24'h5, 24'h0};

	slpx_sleep_exec #(.MS_CYCLES(4)) slpx_sleep_exec_inst (.clk(clk),
		.nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .sleepPin(sleepPin),
		.serialCharRx(serialCharRx), .workPending(workPending),
		.associated(associated), .cmdModeTimeout(cmdModeTimeout),
		.asleep(asleep), .keepAssoc(keepAssoc),
		.hostOutputEnable(hostOutputEnable), .serialRate(serialRate),
		.okPulse(okPulse), .netClearPulse(netClearPulse),
		.softResetPulse(softResetPulse));
	slpx_host_model slpx_host_model_inst (.clk(clk), .sleepPin(sleepPin),
		.serialCharRx(serialCharRx), .workPending(workPending),
		.associated(associated), .cmdModeTimeout(cmdModeTimeout));

	// ------------------------------------------------------------------
	// clock, pulse counters and hang guard
	// ------------------------------------------------------------------
	always #4 clk = ~clk;
	// pulses counted on the falling edge, clear of the launching edge
	always @(negedge clk) begin
		okCount   += okPulse;
		nclrCount += netClearPulse;
		rstCount  += softResetPulse;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 12000) begin
			err_count++;
			finish_test();
		end
	end

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic chk(input string n, input logic [23:0] e, g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// each bus task syncs first, so two strobes never share a time step
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge clk);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge clk);
		regWr    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [23:0] e);
		@(posedge clk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge clk);
		regRd   <= 1'b0;
		#1 chk("regRdata", e, regRdata);
	endtask : rd
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// save answers OK after its store walk
	task automatic cmd(input logic [23:0] b);
		wr(`SLPX_ADDR_CMD, b);
		okExp++;
		tick(b[1] ? 10 : 2);
		chk("okPulse count", 24'(okExp), 24'(okCount));
	endtask : cmd
	task automatic rate(input logic [23:0] e);
		chk("serialRate", e, {16'h0, serialRate});
	endtask : rate
	task automatic wait_sleep(input logic v);
		for (int i = 0; i < 99 && asleep != v; i++)
			@(negedge clk);
		chk("asleep", 24'(v), 24'(asleep));
	endtask : wait_sleep
	task automatic finish_test();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		nrst     = 1'b0;
		regWr    = 1'b0;
		regRd    = 1'b0;
		regAddr  = 8'h00;
		regWdata = 24'h0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rd(`SLPX_ADDR_PERIOD, 24'hc8);
		rd(`SLPX_ADDR_OPTIONS, 24'h100);
		rd(`SLPX_ADDR_WAKETM, 24'h7d0);
		rd(`SLPX_ADDR_ASSOC, 24'h2710);
		rd(`SLPX_ADDR_WAKEDLY, 24'h0);
		wr(`SLPX_ADDR_PERIOD, 24'h83d601);
		rd(`SLPX_ADDR_PERIOD, 24'hc8);
		wr(`SLPX_ADDR_PERIOD, 24'h83d600);
		rd(`SLPX_ADDR_PERIOD, 24'h83d600);
		wr(`SLPX_ADDR_MODE, 24'h2);
		rd(`SLPX_ADDR_MODE, 24'h0);
		foreach (modes[i]) begin
			wr(`SLPX_ADDR_MODE, modes[i]);
			rd(`SLPX_ADDR_MODE, modes[i]);
		end
		// queued rate must not reach the port before a commit
		wr(`SLPX_ADDR_RATE, 24'h5);
		tick(3);
		rate(24'h3);
		cmd(24'h1);
		rate(24'h5);
		wr(`SLPX_ADDR_RATE, 24'h7);
		slpx_host_model_inst.pulse_timeout();
		tick(3);
		rate(24'h7);
		wr(`SLPX_ADDR_RATE, 24'h9);
		cmd(24'h20);
		rate(24'h9);
		wr(`SLPX_ADDR_RATE, 24'ha);
		cmd(24'h40);
		rate(24'ha);
		cmd(24'h10);
		chk("netClearPulse count", 24'h1, 24'(nclrCount));
		// pin sleep keeping association, long host delay on waking
		wr(`SLPX_ADDR_OPTIONS, 24'h140);
		wr(`SLPX_ADDR_WAKEDLY, 24'hffff);
		wr(`SLPX_ADDR_MODE, 24'h1);
		cmd(24'h1);
		slpx_host_model_inst.set_pin(1'b1);
		tick(10);
		chk("asleep", 24'h1, {23'h0, asleep});
		chk("keepAssoc", 24'h1, {23'h0, keepAssoc});
		slpx_host_model_inst.set_pin(1'b0);
		tick(10);
		chk("asleep", 24'h0, {23'h0, asleep});
		chk("hostOutputEnable", 24'h0, {23'h0, hostOutputEnable});
		slpx_host_model_inst.pulse_char();
		tick(4);
		chk("hostOutputEnable", 24'h1, {23'h0, hostOutputEnable});
		// cyclic sleep on the shortest timers
		wr(`SLPX_ADDR_WAKETM, 24'h1);
		wr(`SLPX_ADDR_PERIOD, 24'h1);
		wr(`SLPX_ADDR_MODE, 24'h4);
		cmd(24'h1);
		wait_sleep(1'b1);
		wait_sleep(1'b0);
		chk("hostOutputEnable", 24'h0, {23'h0, hostOutputEnable});
		cmd(24'h4);
		rd(`SLPX_ADDR_RATE, 24'h3);
		rate(24'h3);
		// saved rate must come back after the delayed soft reset
		wr(`SLPX_ADDR_RATE, 24'h6);
		cmd(24'h2);
		wr(`SLPX_ADDR_RATE, 24'h2);
		cmd(24'h8);
		tick(7900);
		chk("softResetPulse count", 24'h0, 24'(rstCount));
		for (int i = 0; i < 200 && rstCount == 0; i++)
			@(posedge clk);
		chk("softResetPulse count", 24'h1, 24'(rstCount));
		tick(20);
		rate(24'h6);
		rd(`SLPX_ADDR_RATE, 24'h6);
		finish_test();
	end
endmodule : slpx_sleep_exec_tb

// File: rtl/slpx_nv_store.sv
/*
 * Small parameter store that stands in for flash: seven words, written one
 * word a cycle, read data registered.
 * Assumes only the hard reset clears it; a soft reboot leaves it intact.
 */
`timescale 1ns/1ps

module slpx_nv_store
	import slpx_pkg::*;
(
	input  wire logic clk,
	input  wire logic nrst,
	slpx_nv_if.mem    nv
);

	slpx_word_t mem_q [`SLPX_NPARAM];

	// ------------------------------------------------------------------
	// storage: power-up content is the factory set
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < `SLPX_NPARAM; i++) begin
				mem_q[i] <= slpxDefault(slpx_idx_t'(i));
			end
		end else if (nv.we) begin
			mem_q[nv.addr] <= nv.wdata;
		end
	end

	// registered read port
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			nv.rdata <= '0;
		end else begin
			nv.rdata <= mem_q[nv.addr];
		end
	end

endmodule : slpx_nv_store

// File: rtl/slpx_sleep_exec.sv
/*
 * Sleep sequencing and execution-command handling of the network module:
 * queued and active parameter sets, sleep state machine, ms/10 ms timers,
 * save/restore of parameters and the delayed soft reboot.
 * Assumes event inputs come from logic on clk; sleepPin is a raw pin.
 */
//
// Function
// - sleep mode codes: 0 none, 1 pin, 4 cyclic, 5 cyclic with pin wake
// - option bit 6 also shapes sleep behaviour
// - sleep period counts 10 ms ticks, 1 to 0x83d600, default 0xc8
// - option 0x40 keeps the network association while asleep
// - option 0x100: receptions never restart the cyclic wake timer
// - nonzero host wake delay holds output that many ms after waking
// - any received serial character stops the host wake delay
// - cyclic wake time in ms, 1 to 0x36ee80, default 0x7d0, no refresh
// - wait up to association timeout ms for association before sleep
// - execution commands act at once, without an apply step
// - configuration writes stay queued until changes are applied
// - leave command and api frame 0x08 also apply queued changes
// - save copies parameter values into non-volatile storage
// - restore loads factory values into every parameter
// - soft reboot answers OK, then resets about 2 s later
// - network clear drops association and clears SSID, parameter ignored
// - leaving command mode by command or timeout applies changes
`timescale 1ns/1ps

module slpx_sleep_exec
	import slpx_pkg::*;
#(
	parameter int MS_CYCLES = `SLPX_MS_NS / `SLPX_CLK_PERIOD_NS
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  regAddr,
	input  wire logic [23:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [23:0] regRdata,
	input  wire logic        sleepPin,
	input  wire logic        serialCharRx,
	input  wire logic        workPending,
	input  wire logic        associated,
	input  wire logic        cmdModeTimeout,
	output logic             asleep,
	output logic             keepAssoc,
	output logic             hostOutputEnable,
	output logic      [7:0]  serialRate,
	output logic             okPulse,
	output logic             netClearPulse,
	output logic             softResetPulse
);

	localparam int MS_TOP = MS_CYCLES - 1;

	slpx_nv_if nv ();

	slpx_nv_store uStore (
		.clk  (clk),
		.nrst (nrst),
		.nv   (nv.mem)
	);

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	slpx_word_t  queued_q [`SLPX_NPARAM];
	slpx_word_t  active_q [`SLPX_NPARAM];
	slpx_state_t state_q, state_d;
	logic [23:0] cnt_q, cnt_d;
	logic [15:0] hostDly_q;
	logic [16:0] msPre_q;
	logic [3:0]  tenPre_q;
	logic        msTick, tenTick, wakeEvt;
	logic        pinMeta_q, pinSync_q;
	logic        xferBusy_q, xferLoad_q, rdValid_q;
	slpx_idx_t   xferIdx_q, rdIdx_q;
	logic        rebootPend_q;
	logic [10:0] rebootCnt_q;
	logic [23:0] rdata_q;
	logic        wrCfg, wrCmd, applyNow, busIdle;
	logic [2:0]  cfgIdx;
	slpx_mode_t  mode;
	logic        cyclic;

	// legal value check, shared by every configuration write
	function automatic logic inRange(input slpx_idx_t i, input slpx_word_t v);
		unique case (i)
			`SLPX_IDX_MODE:    inRange = (v == 24'(SLPX_MODE_NONE)) ||
				(v == 24'(SLPX_MODE_PIN)) || (v == 24'(SLPX_MODE_CYC)) ||
				(v == 24'(SLPX_MODE_CYCPIN));
			`SLPX_IDX_PERIOD:  inRange = (v != '0) &&
				(v <= `SLPX_MAX_PERIOD);
			`SLPX_IDX_OPTIONS: inRange = v <= `SLPX_MAX_OPTIONS;
			`SLPX_IDX_WAKEDLY: inRange = v <= `SLPX_MAX_WAKEDLY;
			`SLPX_IDX_WAKETM,
			`SLPX_IDX_ASSOC:   inRange = (v != '0) &&
				(v <= `SLPX_MAX_MSTIME);
			default:           inRange = v <= `SLPX_MAX_RATE;
		endcase
	endfunction : inRange

	// down-counter step: true when the running count has reached its end
	function automatic logic expired(input logic tick, input logic [23:0] c);
		expired = tick && (c <= 24'h000001);
	endfunction : expired

	// ------------------------------------------------------------------
	// register port decode
	// ------------------------------------------------------------------
	assign cfgIdx   = regAddr[4:2];
	assign wrCfg    = regWr && (regAddr < `SLPX_ADDR_CMD) &&
		(regAddr[1:0] == 2'h0) && busIdle;
	assign wrCmd    = regWr && (regAddr == `SLPX_ADDR_CMD) && busIdle;
	// leaving command mode, explicitly or by timeout, commits the queue
	assign applyNow = (wrCmd && (regWdata[`SLPX_CMD_APPLY] ||
		regWdata[`SLPX_CMD_LEAVE] || regWdata[`SLPX_CMD_API08])) ||
		cmdModeTimeout;
	assign busIdle  = !xferBusy_q && !rdValid_q;
	assign mode     = slpx_mode_t'(active_q[`SLPX_IDX_MODE][2:0]);
	assign cyclic   = (mode == SLPX_MODE_CYC) || (mode == SLPX_MODE_CYCPIN);

	// ------------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pinMeta_q <= 1'b0;
			pinSync_q <= 1'b0;
		end else begin
			pinMeta_q <= sleepPin;
			pinSync_q <= pinMeta_q;
		end
	end

	// ------------------------------------------------------------------
	// tick prescaler: free-running, so a started timer may see its first
	// tick early by up to one tick period
	// ------------------------------------------------------------------
	assign msTick  = (msPre_q == 17'(MS_TOP));
	assign tenTick = msTick && (tenPre_q == `SLPX_TICKS_PER_10MS);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			msPre_q  <= '0;
			tenPre_q <= '0;
		end else begin
			msPre_q <= msTick ? '0 : msPre_q + 17'h00001;
			if (msTick) begin
				tenPre_q <= (tenPre_q == `SLPX_TICKS_PER_10MS) ? '0 :
					tenPre_q + 4'h1;
			end
		end
	end

	// ------------------------------------------------------------------
	// parameter sets: queued writes, apply, restore, load from storage
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < `SLPX_NPARAM; i++) begin
				queued_q[i] <= slpxDefault(slpx_idx_t'(i));
				active_q[i] <= slpxDefault(slpx_idx_t'(i));
			end
		end else begin
			if (wrCfg && inRange(cfgIdx, regWdata)) begin
				queued_q[cfgIdx] <= regWdata;
			end
			if (applyNow) begin
				for (int i = 0; i < `SLPX_NPARAM; i++) begin
					active_q[i] <= queued_q[i];
				end
			end
			if (wrCmd && regWdata[`SLPX_CMD_RESTORE]) begin
				for (int i = 0; i < `SLPX_NPARAM; i++) begin
					queued_q[i] <= slpxDefault(slpx_idx_t'(i));
					active_q[i] <= slpxDefault(slpx_idx_t'(i));
				end
			end
			if (rdValid_q) begin
				queued_q[rdIdx_q] <= nv.rdata;
				active_q[rdIdx_q] <= nv.rdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// copy engine: save walks the queued set into storage, a reboot walks
	// storage back; commands are ignored until the walk ends
	// ------------------------------------------------------------------
	assign nv.we    = xferBusy_q && !xferLoad_q;
	assign nv.addr  = xferIdx_q;
	assign nv.wdata = queued_q[xferIdx_q];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			xferBusy_q <= 1'b0;
			xferLoad_q <= 1'b0;
			xferIdx_q  <= '0;
			rdValid_q  <= 1'b0;
			rdIdx_q    <= '0;
		end else begin
			rdValid_q <= xferBusy_q && xferLoad_q;
			rdIdx_q   <= xferIdx_q;
			if (xferBusy_q) begin
				xferIdx_q <= xferIdx_q + 3'h1;
				if (xferIdx_q == `SLPX_IDX_LAST) begin
					xferBusy_q <= 1'b0;
					xferIdx_q  <= '0;
				end
			end else if (wrCmd && regWdata[`SLPX_CMD_SAVE]) begin
				xferBusy_q <= 1'b1;
				xferLoad_q <= 1'b0;
				xferIdx_q  <= '0;
			end else if (softResetPulse) begin
				xferBusy_q <= 1'b1;
				xferLoad_q <= 1'b1;
				xferIdx_q  <= '0;
			end
		end
	end

	// ------------------------------------------------------------------
	// execution answers: OK pulse, network clear, delayed reboot
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			okPulse        <= 1'b0;
			netClearPulse  <= 1'b0;
			softResetPulse <= 1'b0;
			rebootPend_q   <= 1'b0;
			rebootCnt_q    <= '0;
		end else begin
			// save answers when its last word is stored, others at once
			okPulse <= (wrCmd && !regWdata[`SLPX_CMD_SAVE] &&
				(regWdata[6:0] != 7'h00)) ||
				(xferBusy_q && !xferLoad_q &&
				(xferIdx_q == `SLPX_IDX_LAST));
			// the data word is don't-care beyond the bit itself
			netClearPulse  <= wrCmd && regWdata[`SLPX_CMD_NETCLR];
			softResetPulse <= 1'b0;
			if (wrCmd && regWdata[`SLPX_CMD_REBOOT] && !rebootPend_q) begin
				rebootPend_q <= 1'b1;
				rebootCnt_q  <= `SLPX_REBOOT_MS;
			end else if (rebootPend_q && msTick) begin
				rebootCnt_q <= rebootCnt_q - 11'd1;
				if (rebootCnt_q <= 11'd1) begin
					rebootPend_q   <= 1'b0;
					softResetPulse <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// sleep state machine (next state)
	// ------------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		wakeEvt = 1'b0;
		// receptions are not looked at here: the wake timer never restarts
		unique case (state_q)
			SLPX_AWAKE: begin
				if (mode == SLPX_MODE_PIN && pinSync_q) begin
					state_d = SLPX_SLEEP;
				end else if (cyclic) begin
					state_d = SLPX_WAKE;
					cnt_d   = active_q[`SLPX_IDX_WAKETM];
				end
			end
			SLPX_WAKE: begin
				if (msTick) begin
					cnt_d = cnt_q - 24'h000001;
				end
				if (expired(msTick, cnt_q)) begin
					state_d = SLPX_DRAIN;
				end
			end
			SLPX_DRAIN: begin
				if (!workPending) begin
					state_d = associated ? SLPX_SLEEP : SLPX_ASSOC;
					cnt_d   = associated ? active_q[`SLPX_IDX_PERIOD] :
						active_q[`SLPX_IDX_ASSOC];
				end
			end
			SLPX_ASSOC: begin
				if (msTick) begin
					cnt_d = cnt_q - 24'h000001;
				end
				if (associated || expired(msTick, cnt_q)) begin
					state_d = SLPX_SLEEP;
					cnt_d   = active_q[`SLPX_IDX_PERIOD];
				end
			end
			SLPX_SLEEP: begin
				if (tenTick) begin
					cnt_d = cnt_q - 24'h000001;
				end
				if (mode == SLPX_MODE_PIN && !pinSync_q) begin
					state_d = SLPX_AWAKE;
					wakeEvt = 1'b1;
				end else if (expired(tenTick, cnt_q) ||
					(mode == SLPX_MODE_CYCPIN && !pinSync_q)) begin
					state_d = SLPX_WAKE;
					cnt_d   = active_q[`SLPX_IDX_WAKETM];
					wakeEvt = 1'b1;
				end
			end
			default: begin
				state_d = SLPX_AWAKE;
			end
		endcase
		// a reboot, mode 0, or pin mode outside sleep brings the machine back awake
		if (state_q != SLPX_AWAKE && (softResetPulse ||
			(mode == SLPX_MODE_NONE) ||
			(mode == SLPX_MODE_PIN && state_q != SLPX_SLEEP) ||
			(cyclic && state_q == SLPX_SLEEP && active_q
			[`SLPX_IDX_MODE][2:0] == 3'(SLPX_MODE_PIN)))) begin
			state_d = SLPX_AWAKE;
			wakeEvt = state_q == SLPX_SLEEP;
		end
	end

	// state registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= SLPX_AWAKE;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// ------------------------------------------------------------------
	// host wake delay: loaded on each wake, stopped by any serial byte
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hostDly_q <= '0;
		end else if (serialCharRx) begin
			hostDly_q <= '0;
		end else if (wakeEvt) begin
			hostDly_q <= active_q[`SLPX_IDX_WAKEDLY][15:0];
		end else if (msTick && hostDly_q != 16'h0000) begin
			hostDly_q <= hostDly_q - 16'h0001;
		end
	end

	// ------------------------------------------------------------------
	// registered status outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			asleep           <= 1'b0;
			keepAssoc        <= 1'b0;
			hostOutputEnable <= 1'b1;
			serialRate       <= '0;
		end else begin
			asleep    <= state_d == SLPX_SLEEP;
			// staying associated costs current but shortens the wake-up
			keepAssoc <= (state_d == SLPX_SLEEP) &&
				active_q[`SLPX_IDX_OPTIONS][`SLPX_OPT_KEEPASSOC];
			hostOutputEnable <= (state_d != SLPX_SLEEP) &&
				(hostDly_q == 16'h0000) && !wakeEvt;
			serialRate <= active_q[`SLPX_IDX_RATE][7:0];
		end
	end

	// ------------------------------------------------------------------
	// read port: data stand in the cycle after the strobe
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= '0;
		end else if (regRd) begin
			if (regAddr < `SLPX_ADDR_CMD) begin
				rdata_q <= queued_q[cfgIdx];
			end else if (regAddr == `SLPX_ADDR_STATUS) begin
				rdata_q <= {17'h00000, busIdle, rebootPend_q,
					hostOutputEnable, asleep, state_q};
			end else if (regAddr >= `SLPX_ADDR_ACTIVE &&
				regAddr <= `SLPX_ADDR_TOP) begin
				rdata_q <= active_q[cfgIdx];
			end else begin
				rdata_q <= '0;
			end
		end else begin
			rdata_q <= '0;
		end
	end

	assign regRdata = rdata_q;

endmodule : slpx_sleep_exec
